// ==== shared/mcg_defs.svh ====
// Register offsets, defined-bit masks, reset values for the mode and gain register bank
`ifndef MCG_DEFS_SVH
`define MCG_DEFS_SVH
`define MCG_IDX_COMPUTATION_MODE 16'hE60E
`define MCG_IDX_CHANNEL_GAIN 16'hE60F
`define MCG_RST_COMPUTATION_MODE 16'h01FF
`define MCG_RST_CHANNEL_GAIN 16'h0000
`define MCG_CM_DEFINED_MASK 16'h7FFF
`define MCG_GAIN_DEFINED_MASK 16'h01FF
`define MCG_GAIN_CODE_MAX 3'h4
`define MCG_RESP_OKAY 2'b00
`define MCG_RESP_SLVERR 2'b10
`endif

// ==== shared/mcg_pkg.sv ====
// Types shared by the mode and gain register bank
package mcg_pkg;
  typedef enum logic [1:0] {
    MCG_ANGLE_VOLT_CURR,
    MCG_ANGLE_VOLT_VOLT,
    MCG_ANGLE_CURR_CURR,
    MCG_ANGLE_NONE
  } mcg_angle_t;

  typedef struct packed {
    logic reserved;
    logic network_frequency_select;
    logic [2:0] nominal_volt_use;
    logic [1:0] angle_measure_select;
    logic [2:0] pulse3_phase_include;
    logic [2:0] pulse2_phase_include;
    logic [2:0] pulse1_phase_include;
  } mcg_computation_mode_t;

  typedef struct packed {
    logic [6:0] reserved;
    logic [2:0] phase_voltage_gain;
    logic [2:0] neutral_current_gain;
    logic [2:0] phase_current_gain;
  } mcg_gain_t;

  typedef struct packed {
    logic [4:0] phase_current;
    logic [4:0] neutral_current;
    logic [4:0] phase_voltage;
  } mcg_gain_factor_t;
endpackage

// ==== verilog/mcg_regs.sv ====
// Computation mode and channel gain registers behind an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "mcg_defs.svh"

// Function
// RULE_01: Bits 0-2 include phases in pulse 1
// RULE_02: Bits 3-5 include phases in pulse 2
// RULE_03: Bits 6-8 include phases in pulse 3
// RULE_04: Bits 10:9 select angle measurement mode
// RULE_05: Bits 11-13 substitute nominal voltage per phase
// RULE_06: Software sets bit 14 for 60 Hz
// RULE_07: Mode bit 15 reserved, reads zero
// RULE_08: Phase current gain codes give 1..16
// RULE_09: Reserved phase current codes act as unity
// RULE_10: Neutral gain same codes, reserved act unity
// RULE_11: No neutral channel holds field at zero
// RULE_12: Phase voltage gain codes, reserved act unity
// RULE_13: Gain bits 15:9 reserved, read zero
// RULE_14: Pulse sums gated by phase include bits
// RULE_15: Reads return held fields, reserved zero
module mcg_regs
  import mcg_pkg::*;
#(
  parameter bit HAS_NEUTRAL = 1'b1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] PHASE_POWER_VALID,
  input wire logic signed [23:0] PHASE_A_POWER,
  input wire logic signed [23:0] PHASE_B_POWER,
  input wire logic signed [23:0] PHASE_C_POWER,
  output logic signed [25:0] PULSE_OUTPUT_1_SUM,
  output logic signed [25:0] PULSE_OUTPUT_2_SUM,
  output logic signed [25:0] PULSE_OUTPUT_3_SUM,
  output mcg_computation_mode_t COMPUTATION_MODE,
  output mcg_angle_t ANGLE_MEASURE_SELECT,
  output logic [2:0] NOMINAL_VOLT_USE,
  output logic NETWORK_FREQUENCY_SELECT,
  output mcg_gain_t CHANNEL_GAIN,
  output mcg_gain_factor_t GAIN_FACTOR
);

  // Byte address is the low 16 bits of four times the printed index
  localparam logic [15:0] ADDR_MODE = 16'(`MCG_IDX_COMPUTATION_MODE << 2);
  localparam logic [15:0] ADDR_GAIN = 16'(`MCG_IDX_CHANNEL_GAIN << 2);

  mcg_computation_mode_t mode;
  mcg_gain_t gain;
  logic [15:0] aw_addr;
  logic aw_held;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  logic w_held;
  logic [15:0] next_mode;
  logic [15:0] next_gain;
  logic do_write;
  logic signed [25:0] next_sum [3];

  // Reserved codes fall back to unity gain
  function automatic logic [4:0] gain_factor(input logic [2:0] code);
    if (code > `MCG_GAIN_CODE_MAX) begin
      gain_factor = 5'h01; // RULE_09 RULE_10 RULE_12
    end else begin
      gain_factor = 5'(5'h01 << code); // RULE_08
    end
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] st);
    merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  always_comb begin
    next_mode = merge(mode, w_data, w_strb) & `MCG_CM_DEFINED_MASK; // RULE_07
    next_gain = merge(gain, w_data, w_strb) & `MCG_GAIN_DEFINED_MASK; // RULE_13
    if (!HAS_NEUTRAL) begin
      next_gain[5:3] = 3'h0; // RULE_11
    end
  end

  // Address and data are taken independently, in either order
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= 16'h0000;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      w_held <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 2'b00;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_held && !S_AXI_WREADY;
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA[15:0];
        w_strb <= S_AXI_WSTRB[1:0];
        S_AXI_WREADY <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mode <= mcg_computation_mode_t'(`MCG_RST_COMPUTATION_MODE); // RULE_01 RULE_02 RULE_03
      gain <= mcg_gain_t'(`MCG_RST_CHANNEL_GAIN);
    end else if (do_write) begin
      if (aw_addr[15:2] == ADDR_MODE[15:2]) begin
        mode <= mcg_computation_mode_t'(next_mode);
      end
      if (aw_addr[15:2] == ADDR_GAIN[15:2]) begin
        gain <= mcg_gain_t'(next_gain);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `MCG_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr[15:2] == ADDR_MODE[15:2] || aw_addr[15:2] == ADDR_GAIN[15:2])
                     ? `MCG_RESP_OKAY : `MCG_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read data comes one cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `MCG_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && !S_AXI_ARVALID ? 1'b1 :
                       (!S_AXI_RVALID && !S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `MCG_RESP_OKAY;
        if (S_AXI_ARADDR[15:2] == ADDR_MODE[15:2]) begin
          S_AXI_RDATA <= {16'h0000, 16'(mode) & `MCG_CM_DEFINED_MASK}; // RULE_15
        end else if (S_AXI_ARADDR[15:2] == ADDR_GAIN[15:2]) begin
          S_AXI_RDATA <= {16'h0000, 16'(gain) & `MCG_GAIN_DEFINED_MASK}; // RULE_15
        end else begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= `MCG_RESP_SLVERR;
        end
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Phase sums for each pulse output; source power type is chosen upstream
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      logic [2:0] inc;
      inc = (k == 0) ? mode.pulse1_phase_include :
            (k == 1) ? mode.pulse2_phase_include : mode.pulse3_phase_include;
      next_sum[k] = (inc[0] ? 26'(PHASE_A_POWER) : 26'sd0) +
                    (inc[1] ? 26'(PHASE_B_POWER) : 26'sd0) +
                    (inc[2] ? 26'(PHASE_C_POWER) : 26'sd0); // RULE_14
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PULSE_OUTPUT_1_SUM <= 26'sd0;
      PULSE_OUTPUT_2_SUM <= 26'sd0;
      PULSE_OUTPUT_3_SUM <= 26'sd0;
    end else if (&PHASE_POWER_VALID) begin
      PULSE_OUTPUT_1_SUM <= next_sum[0]; // RULE_01
      PULSE_OUTPUT_2_SUM <= next_sum[1]; // RULE_02
      PULSE_OUTPUT_3_SUM <= next_sum[2]; // RULE_03
    end
  end

  // Decoded controls are registered so every output leaves a flip-flop
  always_ff @(posedge CLK) begin
    if (RST) begin
      COMPUTATION_MODE <= mcg_computation_mode_t'(`MCG_RST_COMPUTATION_MODE);
      ANGLE_MEASURE_SELECT <= MCG_ANGLE_VOLT_CURR;
      NOMINAL_VOLT_USE <= 3'h0;
      NETWORK_FREQUENCY_SELECT <= 1'b0;
      CHANNEL_GAIN <= mcg_gain_t'(`MCG_RST_CHANNEL_GAIN);
      GAIN_FACTOR <= {5'h01, 5'h01, 5'h01};
    end else begin
      COMPUTATION_MODE <= mode;
      ANGLE_MEASURE_SELECT <= mcg_angle_t'(mode.angle_measure_select); // RULE_04
      NOMINAL_VOLT_USE <= mode.nominal_volt_use; // RULE_05
      NETWORK_FREQUENCY_SELECT <= mode.network_frequency_select; // RULE_06
      CHANNEL_GAIN <= gain;
      GAIN_FACTOR.phase_current <= gain_factor(gain.phase_current_gain); // RULE_08
      GAIN_FACTOR.neutral_current <= gain_factor(gain.neutral_current_gain); // RULE_10
      GAIN_FACTOR.phase_voltage <= gain_factor(gain.phase_voltage_gain); // RULE_12
    end
  end

  property p_reserved_zero;
    @(posedge CLK) disable iff (RST)
      !mode.reserved && gain.reserved == 7'h00 && !COMPUTATION_MODE.reserved;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RULE_07

  property p_gain_reserved;
    @(posedge CLK) disable iff (RST)
      gain.phase_current_gain > 3'h4 |=> GAIN_FACTOR.phase_current == 5'h01;
  endproperty
  a_gain_reserved: assert property (p_gain_reserved) else $error("reserved code not unity"); // RULE_09

  property p_gain_decode;
    @(posedge CLK) disable iff (RST)
      gain.phase_voltage_gain == 3'h4 |=> GAIN_FACTOR.phase_voltage == 5'h10;
  endproperty
  a_gain_decode: assert property (p_gain_decode) else $error("voltage gain 16 wrong"); // RULE_12

  property p_neutral_held;
    @(posedge CLK) disable iff (RST) !HAS_NEUTRAL |-> gain.neutral_current_gain == 3'h0;
  endproperty
  a_neutral_held: assert property (p_neutral_held) else $error("neutral gain not held"); // RULE_11

  property p_angle_follow;
    @(posedge CLK) disable iff (RST)
      1'b1 |=> ANGLE_MEASURE_SELECT == mcg_angle_t'($past(mode.angle_measure_select));
  endproperty
  a_angle_follow: assert property (p_angle_follow) else $error("angle select lags"); // RULE_04

  property p_nominal_follow;
    @(posedge CLK) disable iff (RST) $changed(mode.nominal_volt_use) |=>
      NOMINAL_VOLT_USE == $past(mode.nominal_volt_use);
  endproperty
  a_nominal_follow: assert property (p_nominal_follow) else $error("nominal use lags"); // RULE_05

  property p_sum_single;
    @(posedge CLK) disable iff (RST)
      (&PHASE_POWER_VALID && mode.pulse1_phase_include == 3'b001) |=>
      PULSE_OUTPUT_1_SUM == 26'($past(PHASE_A_POWER));
  endproperty
  a_sum_single: assert property (p_sum_single) else $error("pulse 1 sum wrong"); // RULE_14

  property p_read_mode;
    @(posedge CLK) disable iff (RST)
      (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[15:2] == ADDR_MODE[15:2]) |=>
      S_AXI_RVALID && S_AXI_RDATA[31:15] == 17'h0;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("mode readback wrong"); // RULE_15

  property p_read_gain;
    @(posedge CLK) disable iff (RST)
      (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[15:2] == ADDR_GAIN[15:2]) |=>
      S_AXI_RVALID && S_AXI_RDATA[31:9] == 23'h0;
  endproperty
  a_read_gain: assert property (p_read_gain) else $error("gain readback wrong"); // RULE_13

  // Checked through reset as well, so the default lands before the first access
  property p_mode_reset;
    @(posedge CLK) RST |=> 16'(mode) == `MCG_RST_COMPUTATION_MODE;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode reset value wrong"); // RULE_01

  property p_neutral_rsvd;
    @(posedge CLK) disable iff (RST)
      gain.neutral_current_gain > 3'h4 |=> GAIN_FACTOR.neutral_current == 5'h01;
  endproperty
  a_neutral_rsvd: assert property (p_neutral_rsvd) else $error("neutral not unity"); // RULE_10

  property p_volt_rsvd;
    @(posedge CLK) disable iff (RST)
      gain.phase_voltage_gain > 3'h4 |=> GAIN_FACTOR.phase_voltage == 5'h01;
  endproperty
  a_volt_rsvd: assert property (p_volt_rsvd) else $error("voltage not unity"); // RULE_12

  property p_curr_decode;
    @(posedge CLK) disable iff (RST)
      gain.phase_current_gain == 3'h3 |=> GAIN_FACTOR.phase_current == 5'h08;
  endproperty
  a_curr_decode: assert property (p_curr_decode) else $error("current gain 8 wrong"); // RULE_08

  property p_sum_all;
    @(posedge CLK) disable iff (RST)
      (&PHASE_POWER_VALID && mode.pulse2_phase_include == 3'b111) |=>
      PULSE_OUTPUT_2_SUM == 26'($past(PHASE_A_POWER)) + 26'($past(PHASE_B_POWER)) +
      26'($past(PHASE_C_POWER));
  endproperty
  a_sum_all: assert property (p_sum_all) else $error("pulse 2 sum wrong"); // RULE_02

endmodule

// ==== dv/tb_metering_compute_mode_and_gain_regs.sv ====
// Self-checking bench for the mode and gain register bank
`include "mcg_defs.svh"
module tb_metering_compute_mode_and_gain_regs
  import mcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Offsets are word indices; the 16-bit bus carries the low 16 bits of four times the index
  localparam logic [17:0] CM_BYTE = {`MCG_IDX_COMPUTATION_MODE, 2'b00};
  localparam logic [17:0] GN_BYTE = {`MCG_IDX_CHANNEL_GAIN, 2'b00};
  localparam logic [15:0] A_CM = CM_BYTE[15:0];
  localparam logic [15:0] A_GN = GN_BYTE[15:0];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] pvalid = '0;
  logic signed [23:0] pa = '0, pb = '0, pc = '0;
  logic awready, wready, bvalid, arready, rvalid, nfs;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic signed [25:0] sum1, sum2, sum3;
  mcg_computation_mode_t cm_out;
  mcg_angle_t angle;
  logic [2:0] nvu;
  mcg_gain_t gain_out;
  mcg_gain_factor_t factor;
  mcg_gain_t gain_nn;
  mcg_gain_factor_t factor_nn;
  int error_cnt = 0;
  int num_checks = 0;

  mcg_regs i_mcg_regs (
    .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PHASE_POWER_VALID(pvalid), .PHASE_A_POWER(pa), .PHASE_B_POWER(pb),
    .PHASE_C_POWER(pc), .PULSE_OUTPUT_1_SUM(sum1), .PULSE_OUTPUT_2_SUM(sum2),
    .PULSE_OUTPUT_3_SUM(sum3), .COMPUTATION_MODE(cm_out), .ANGLE_MEASURE_SELECT(angle),
    .NOMINAL_VOLT_USE(nvu), .NETWORK_FREQUENCY_SELECT(nfs), .CHANNEL_GAIN(gain_out),
    .GAIN_FACTOR(factor)
  );

  // Twin without a neutral channel runs in lockstep on the same bus; only its gain and gain factor are watched
  mcg_regs #(.HAS_NEUTRAL(1'b0)) i_mcg_regs_no_neutral (
    .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(), .S_AXI_BRESP(),
    .S_AXI_BVALID(), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(), .S_AXI_RDATA(),
    .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready),
    .PHASE_POWER_VALID(pvalid), .PHASE_A_POWER(pa), .PHASE_B_POWER(pb),
    .PHASE_C_POWER(pc), .PULSE_OUTPUT_1_SUM(), .PULSE_OUTPUT_2_SUM(),
    .PULSE_OUTPUT_3_SUM(), .COMPUTATION_MODE(), .ANGLE_MEASURE_SELECT(),
    .NOMINAL_VOLT_USE(), .NETWORK_FREQUENCY_SELECT(), .CHANNEL_GAIN(gain_nn),
    .GAIN_FACTOR(factor_nn)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Derived ports trail the register by a cycle; sample off the edge
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic axw(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    settle();
    chk("mode_port", 32'(cm_out), 32'h0000_01FF);
    chk("factor_port", 32'(factor), {17'd0, 5'd1, 5'd1, 5'd1});
    axr(A_CM, d, r);
    chk("mode_rd", d, 32'h0000_01FF);
    chk("mode_rresp", 32'(r), 32'(`MCG_RESP_OKAY));
    axr(A_GN, d, r);
    chk("gain_rd", d, 32'h0000_0000);
  endtask

  // Upper half is always written as ABCD and bit 15 as one; both must vanish
  task automatic t_mode();
    logic [31:0] d, e;
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      e = {17'd0, k[0], 3'(3'b001 << (k % 3)), k[1:0], 9'h1FF};
      axw(A_CM, e | 32'hABCD_8000, r);
      chk("mode_bresp", 32'(r), 32'(`MCG_RESP_OKAY));
      axr(A_CM, d, r);
      chk("mode_rd", d, e);
      settle();
      chk("angle", 32'(angle), 32'(k));
      chk("nominal", 32'(nvu), 32'(1) << (k % 3));
      chk("freq", 32'(nfs), 32'(k[0]));
    end
  endtask

  task automatic t_gain();
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] g;
    logic [4:0] f;
    for (int c = 0; c < 8; c++) begin
      g = c[2:0];
      f = (c <= 4) ? 5'(5'd1 << c) : 5'd1;
      axw(A_GN, {23'h7F_FFFF, g, g, g}, r);
      axr(A_GN, d, r);
      chk("gain_rd", d, {23'd0, g, g, g});
      settle();
      chk("gain_port", 32'(gain_out), {23'd0, g, g, g});
      chk("factor", 32'(factor), {17'd0, f, f, f});
      chk("gain_nn", 32'(gain_nn), {23'd0, g, 3'h0, g});
      chk("factor_nn", 32'(factor_nn), {17'd0, f, 5'd1, f});
    end
  endtask

  function automatic logic signed [25:0] psum(input logic [2:0] inc);
    return (inc[0] ? 26'(pa) : 26'sd0) + (inc[1] ? 26'(pb) : 26'sd0)
      + (inc[2] ? 26'(pc) : 26'sd0);
  endfunction

  task automatic t_sums();
    logic [8:0] pat [3] = '{9'b101_110_001, 9'b010_011_100, 9'b000_111_111};
    logic [1:0] r;
    @(posedge clk);
    pa <= 24'sd1000;
    pb <= -24'sd300;
    pc <= 24'sd50000;
    pvalid <= 3'b111;
    for (int i = 0; i < 3; i++) begin
      axw(A_CM, {23'd0, pat[i]}, r);
      settle();
      chk("sum1", 32'(sum1), 32'(psum(pat[i][2:0])));
      chk("sum2", 32'(sum2), 32'(psum(pat[i][5:3])));
      chk("sum3", 32'(sum3), 32'(psum(pat[i][8:6])));
    end
    // A partly valid set of phase powers must leave the sums alone
    @(posedge clk);
    pvalid <= 3'b011;
    pa <= 24'sd7;
    settle();
    chk("sum1_hold", 32'(sum1), 32'sd50700);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axw(A_CM + 16'h0010, 32'h0000_FFFF, r);
    chk("bad_bresp", 32'(r), 32'(`MCG_RESP_SLVERR));
    axr(A_CM + 16'h0010, d, r);
    chk("bad_rd", d, 32'h0000_0000);
    chk("bad_rresp", 32'(r), 32'(`MCG_RESP_SLVERR));
    axr(A_CM, d, r);
    chk("mode_kept", d, 32'h0000_003F);
    // Upper byte lane only; the lower byte must survive the write
    wstrb <= 4'h2;
    axw(A_CM, 32'h0000_7E80, r);
    wstrb <= 4'hF;
    axr(A_CM, d, r);
    chk("mode_lane", d, 32'h0000_7E3F);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode();
    t_gain();
    t_sums();
    t_unmapped();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
